//--- rtl/frc_pkg.sv
// Purpose: constants for the receive completion state machine
// Assumes: one port, single 100 MHz clock, synchronous active-high reset
// Notes:   state codes are one-hot
//
// Functional notes
// - on set-bits FIS with interrupt flag, set status; if enabled, go to global-status state
// - set-bits global-status state sets this port's pending bit
// - global-status goes to interrupt generation first when global enable set
// - else go switching idle if snapshot zero and switching on; idle if zero; else pm
// - direct idle exits keep notification events out of aggressive power management
// - set-bits interrupt generation state asserts the port interrupt
// - generated interrupt stays until software clears it
// - unknown FIS handled only when its CRC is good
// - unknown diag flag set immediately on recognising an unknown FIS
// - unknown FIS copied to memory first, then unknown status set
// - after unknown entry go global-status if enabled, else switching idle, else idle
// - unknown global-status sets pending bit, then interrupt, switching idle or idle
// - unknown interrupt generation asserts interrupt, then switching idle or idle
// - far-end loopback entered on self-test activate FIS with far-end mode
// - loopback writes detect state 4h, then moves to self-test running
// - self-test running holds until software clears run control
package frc_pkg;
  localparam logic [3:0] DET_LOOPBACK = 4'h4;
  localparam logic [3:0] DET_RESET    = 4'h0;

  typedef enum logic [12:0] {
    FRC_IDLE     = 13'h0001,
    FRC_SDB_INT  = 13'h0002,
    FRC_SDB_IS   = 13'h0004,
    FRC_SDB_GEN  = 13'h0008,
    FRC_UF_COPY  = 13'h0010,
    FRC_UF_ENTRY = 13'h0020,
    FRC_UF_IS    = 13'h0040,
    FRC_UF_GEN   = 13'h0080,
    FRC_LOOPBACK = 13'h0100,
    FRC_BIST_RUN = 13'h0200,
    FRC_SWITCHING_IDLE_STATE  = 13'h0400,
    FRC_P_IDLE   = 13'h0800,
    FRC_AGGRESSIVE_PM_CHECK_STATE  = 13'h1000
  } frc_state_t;
endpackage : frc_pkg

//--- rtl/frc_sticky.sv
// Purpose: sticky flag bit, hardware set wins over software clear
// Assumes: single clock, synchronous reset
// Notes:   none
`timescale 1ns/1ps
module frc_sticky (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);
  logic next_flag;
  always_comb begin
    next_flag = flag;
    if (clear) begin
      next_flag = 1'b0;
    end
    if (set) begin
      next_flag = 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule : frc_sticky

//--- rtl/frc_fsm.sv
// Purpose: set-bits completion, unknown FIS receive and far-end loopback states
// Assumes: event inputs are one-cycle pulses from same-clock receive logic
//          enables, run control and clear pulses come from registers on the same clock
// Notes:   idle and power states are only reported, then return to frc_idle
//          every output is a flip-flop; the state flags are registered from next_state,
//          so they stand in exactly the cycles of the state that they report
`timescale 1ns/1ps
module frc_fsm #(
  parameter int PORTS    = 1,
  parameter int PORT_IDX = 0
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             sdb_fis_int,
  input  wire logic             sdb_active_zero,
  input  wire logic             unknown_fis_rx,
  input  wire logic             unknown_fis_crc_ok,
  input  wire logic             bist_far_end_rx,
  input  wire logic             copy_done,
  input  wire logic             set_bits_fis_int_enable,
  input  wire logic             unknown_fis_int_enable,
  input  wire logic             global_interrupt_enable,
  input  wire logic             fis_switching_enable,
  input  wire logic             port_run_control,
  input  wire logic             clr_set_bits_fis_status,
  input  wire logic             clr_unknown_fis_status,
  input  wire logic             clr_unknown_fis_diag_flag,
  input  wire logic [PORTS-1:0] clr_pending,
  output logic                  set_bits_fis_status,
  output logic                  unknown_fis_status,
  output logic                  unknown_fis_diag_flag,
  output logic [PORTS-1:0]      port_interrupt_pending_bits,
  output logic                  port_interrupt,
  output logic                  irq,
  output logic                  copy_req,
  output logic [3:0]            link_detect_state,
  output logic                  self_test_running_state,
  output logic                  switching_idle_state,
  output logic                  port_idle_state,
  output logic                  aggressive_pm_check_state
);
  // refuse port settings that the pending vector cannot index
  if (PORTS < 1 || PORT_IDX < 0 || PORT_IDX >= PORTS) begin : g_bad_ports
    $error("frc_fsm: bad port parameters");
  end

  // one-hot state register, the next values of the outputs registered below, and the set strobes of the sticky flags
  frc_pkg::frc_state_t state;
  frc_pkg::frc_state_t next_state;
  logic                next_port_interrupt;
  logic                next_irq;
  logic                next_copy_req;
  logic [3:0]          next_link_detect_state;
  logic                next_self_test_running_state;
  logic                next_switching_idle_state;
  logic                next_port_idle_state;
  logic                next_aggressive_pm_check_state;
  logic                set_sdbs;
  logic                set_ufs;
  logic                set_pend;
  logic [PORTS-1:0]    pend_set_vec;
  logic [PORTS-1:0]    next_pend;

  // idle exit used by the unknown FIS states
  function automatic frc_pkg::frc_state_t uf_exit(input logic fbs);
    uf_exit = fbs ? frc_pkg::FRC_SWITCHING_IDLE_STATE : frc_pkg::FRC_P_IDLE;
  endfunction : uf_exit

  // idle exit used by the set-bits states
  function automatic frc_pkg::frc_state_t sdb_exit(input logic zero, input logic fbs);
    if (zero && fbs) sdb_exit = frc_pkg::FRC_SWITCHING_IDLE_STATE;
    else if (zero)   sdb_exit = frc_pkg::FRC_P_IDLE;
    else             sdb_exit = frc_pkg::FRC_AGGRESSIVE_PM_CHECK_STATE;
  endfunction : sdb_exit

  always_comb begin
    next_state             = state;
    next_port_interrupt    = port_interrupt;
    next_copy_req          = 1'b0;
    next_link_detect_state = link_detect_state;
    set_sdbs               = 1'b0;
    set_ufs                = 1'b0;
    set_pend               = 1'b0;
    // stopping the port withdraws the interrupt, except in the generation states, which assert it
    if (!port_run_control) begin
      next_port_interrupt = 1'b0;
    end
    unique case (state)
      frc_pkg::FRC_IDLE: begin
        // events are taken only here: loopback, then good unknown FIS, then set-bits
        if (bist_far_end_rx) begin
          next_state = frc_pkg::FRC_LOOPBACK;
        end else if (unknown_fis_rx && unknown_fis_crc_ok) begin
          next_state    = frc_pkg::FRC_UF_COPY;
          next_copy_req = 1'b1;
        end else if (sdb_fis_int) begin
          next_state = frc_pkg::FRC_SDB_INT;
        end
      end
      frc_pkg::FRC_SDB_INT: begin
        set_sdbs = 1'b1;
        if (set_bits_fis_int_enable) next_state = frc_pkg::FRC_SDB_IS;
        else next_state = sdb_exit(sdb_active_zero, fis_switching_enable);
      end
      frc_pkg::FRC_SDB_IS: begin
        set_pend = 1'b1;
        if (global_interrupt_enable) next_state = frc_pkg::FRC_SDB_GEN;
        else next_state = sdb_exit(sdb_active_zero, fis_switching_enable);
      end
      frc_pkg::FRC_SDB_GEN: begin
        next_port_interrupt = 1'b1;
        next_state = sdb_exit(sdb_active_zero, fis_switching_enable);
      end
      frc_pkg::FRC_UF_COPY: begin
        // hold the copy request until memory answers, status waits for the copy
        next_copy_req = !copy_done;
        if (copy_done) next_state = frc_pkg::FRC_UF_ENTRY;
      end
      frc_pkg::FRC_UF_ENTRY: begin
        set_ufs = 1'b1;
        if (unknown_fis_int_enable) next_state = frc_pkg::FRC_UF_IS;
        else next_state = uf_exit(fis_switching_enable);
      end
      frc_pkg::FRC_UF_IS: begin
        set_pend = 1'b1;
        if (global_interrupt_enable) next_state = frc_pkg::FRC_UF_GEN;
        else next_state = uf_exit(fis_switching_enable);
      end
      frc_pkg::FRC_UF_GEN: begin
        next_port_interrupt = 1'b1;
        next_state = uf_exit(fis_switching_enable);
      end
      frc_pkg::FRC_LOOPBACK: begin
        next_link_detect_state = frc_pkg::DET_LOOPBACK;
        next_state = frc_pkg::FRC_BIST_RUN;
      end
      frc_pkg::FRC_BIST_RUN: begin
        // the test body runs outside this block; only software stops it
        if (!port_run_control) next_state = frc_pkg::FRC_IDLE;
      end
      frc_pkg::FRC_SWITCHING_IDLE_STATE, frc_pkg::FRC_P_IDLE, frc_pkg::FRC_AGGRESSIVE_PM_CHECK_STATE: begin
        // exits are reported for one cycle, then the next event may be taken
        next_state = frc_pkg::FRC_IDLE;
      end
      default: begin
        // illegal one-hot code: recover to idle
        next_state = frc_pkg::FRC_IDLE;
      end
    endcase
    // software ends the interrupt by clearing this port's pending bit, unless that bit is set again in the same cycle
    if (port_interrupt && clr_pending[PORT_IDX] && !set_pend) begin
      next_port_interrupt = 1'b0;
    end
    pend_set_vec = '0;
    pend_set_vec[PORT_IDX] = set_pend;
    // pending value after this edge, so irq drops in the same cycle as a clear
    next_pend = (port_interrupt_pending_bits & ~clr_pending) | pend_set_vec;
    next_irq = global_interrupt_enable && (|next_pend);
    // state flags stand in the same cycles as the state they report
    next_self_test_running_state   = next_state == frc_pkg::FRC_BIST_RUN;
    next_switching_idle_state      = next_state == frc_pkg::FRC_SWITCHING_IDLE_STATE;
    next_port_idle_state           = next_state == frc_pkg::FRC_P_IDLE;
    next_aggressive_pm_check_state = next_state == frc_pkg::FRC_AGGRESSIVE_PM_CHECK_STATE;
  end

  // registers only; all decisions are made in the process above
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state                     <= frc_pkg::FRC_IDLE;
      port_interrupt            <= 1'b0;
      irq                       <= 1'b0;
      copy_req                  <= 1'b0;
      link_detect_state         <= frc_pkg::DET_RESET;
      self_test_running_state   <= 1'b0;
      switching_idle_state      <= 1'b0;
      port_idle_state           <= 1'b0;
      aggressive_pm_check_state <= 1'b0;
    end else begin
      state                     <= next_state;
      port_interrupt            <= next_port_interrupt;
      irq                       <= next_irq;
      copy_req                  <= next_copy_req;
      link_detect_state         <= next_link_detect_state;
      self_test_running_state   <= next_self_test_running_state;
      switching_idle_state      <= next_switching_idle_state;
      port_idle_state           <= next_port_idle_state;
      aggressive_pm_check_state <= next_aggressive_pm_check_state;
    end
  end

  // status flags: a hardware set wins over a software clear in the same cycle
  frc_sticky u_sdbs (
    .sys_clk (sys_clk),
    .reset   (reset),
    .set     (set_sdbs),
    .clear   (clr_set_bits_fis_status),
    .flag    (set_bits_fis_status)
  );
  frc_sticky u_ufs (
    .sys_clk (sys_clk),
    .reset   (reset),
    .set     (set_ufs),
    .clear   (clr_unknown_fis_status),
    .flag    (unknown_fis_status)
  );
  frc_sticky u_diag (
    .sys_clk (sys_clk),
    .reset   (reset),
    .set     (unknown_fis_rx),
    .clear   (clr_unknown_fis_diag_flag),
    .flag    (unknown_fis_diag_flag)
  );
  // one pending bit per port; only this port's bit is ever set here
  for (genvar i = 0; i < PORTS; i++) begin : g_pend
    frc_sticky u_pend (
      .sys_clk (sys_clk),
      .reset   (reset),
      .set     (pend_set_vec[i]),
      .clear   (clr_pending[i]),
      .flag    (port_interrupt_pending_bits[i])
    );
  end
endmodule : frc_fsm

//--- testbench/frc_props.sv
// Purpose: port checks for frc_fsm
// Assumes: one clock, sync reset
// Notes: bound from the bench
`timescale 1ns/1ps
module frc_props #(parameter int PORTS = 1) (
  input wire logic             sys_clk,
  input wire logic             reset,
  input wire logic             sdb_fis_int,
  input wire logic             unknown_fis_rx,
  input wire logic             unknown_fis_crc_ok,
  input wire logic             copy_done,
  input wire logic             global_interrupt_enable,
  input wire logic             port_run_control,
  input wire logic [PORTS-1:0] clr_pending,
  input wire logic             set_bits_fis_status,
  input wire logic             unknown_fis_status,
  input wire logic             unknown_fis_diag_flag,
  input wire logic [PORTS-1:0] port_interrupt_pending_bits,
  input wire logic             port_interrupt,
  input wire logic             irq,
  input wire logic             copy_req,
  input wire logic [3:0]       link_detect_state,
  input wire logic             self_test_running_state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence bad_uf_s;
    unknown_fis_rx && !unknown_fis_crc_ok;
  endsequence
  sdb_status_a: assert property (sdb_fis_int |-> ##[1:3] set_bits_fis_status)
    else $error("set-bits status late");
  diag_flag_a: assert property (unknown_fis_rx |=> unknown_fis_diag_flag)
    else $error("diag flag not set");
  crc_refuse_a: assert property (bad_uf_s |=> !copy_req)
    else $error("bad crc started copy");
  ufs_order_a: assert property (copy_done |-> ##[1:3] unknown_fis_status)
    else $error("unknown status late");
  det_loop_a: assert property ($rose(self_test_running_state) |->
    link_detect_state == frc_pkg::DET_LOOPBACK)
    else $error("detect state wrong");
  test_hold_a: assert property (self_test_running_state && port_run_control |=>
    self_test_running_state)
    else $error("self-test dropped");
  intr_hold_a: assert property (port_interrupt && port_run_control && !clr_pending[0]
    |=> port_interrupt)
    else $error("interrupt dropped");
  irq_level_a: assert property (
    (global_interrupt_enable && |port_interrupt_pending_bits) [*2] |-> irq)
    else $error("irq low");
endmodule : frc_props

//--- testbench/frc_mem_model.sv
// Purpose: system memory answering the unknown frame copy
// Assumes: copy_req held until copy_done seen
// Notes: lat sets the answer delay
`timescale 1ns/1ps
module frc_mem_model (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       copy_req,
  input wire logic [3:0] lat,
  output logic           copy_done
);
  logic [3:0] cnt;
  always_ff @(posedge sys_clk) begin
    copy_done <= 1'b0;
    if (reset || !copy_req) begin
      cnt <= 4'h0;
    end else if (cnt == lat) begin
      copy_done <= 1'b1;
      cnt <= 4'hf;
    end else if (cnt != 4'hf) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : frc_mem_model

//--- testbench/tb_frc_fsm.sv
// Purpose: self-checking bench for frc_fsm
// Assumes: one port
// Notes: events only while idle
`timescale 1ns/1ps
module tb_frc_fsm;
  logic sys_clk, reset, sdb_fis_int, sdb_active_zero, unknown_fis_rx, unknown_fis_crc_ok;
  logic bist_far_end_rx, copy_done, set_bits_fis_int_enable, unknown_fis_int_enable;
  logic global_interrupt_enable, fis_switching_enable, port_run_control, irq, copy_req;
  logic clr_set_bits_fis_status, clr_unknown_fis_status, clr_unknown_fis_diag_flag;
  logic set_bits_fis_status, unknown_fis_status, unknown_fis_diag_flag, port_interrupt;
  logic self_test_running_state, switching_idle_state, port_idle_state, aggressive_pm_check_state;
  logic [0:0] clr_pending, port_interrupt_pending_bits;
  logic [3:0] link_detect_state, lat;
  int         miscompares, total_checks;
  frc_fsm uut (
    .sys_clk                     (sys_clk),
    .reset                       (reset),
    .sdb_fis_int                 (sdb_fis_int),
    .sdb_active_zero             (sdb_active_zero),
    .unknown_fis_rx              (unknown_fis_rx),
    .unknown_fis_crc_ok          (unknown_fis_crc_ok),
    .bist_far_end_rx             (bist_far_end_rx),
    .copy_done                   (copy_done),
    .set_bits_fis_int_enable     (set_bits_fis_int_enable),
    .unknown_fis_int_enable      (unknown_fis_int_enable),
    .global_interrupt_enable     (global_interrupt_enable),
    .fis_switching_enable        (fis_switching_enable),
    .port_run_control            (port_run_control),
    .clr_set_bits_fis_status     (clr_set_bits_fis_status),
    .clr_unknown_fis_status      (clr_unknown_fis_status),
    .clr_unknown_fis_diag_flag   (clr_unknown_fis_diag_flag),
    .clr_pending                 (clr_pending),
    .set_bits_fis_status         (set_bits_fis_status),
    .unknown_fis_status          (unknown_fis_status),
    .unknown_fis_diag_flag       (unknown_fis_diag_flag),
    .port_interrupt_pending_bits (port_interrupt_pending_bits),
    .port_interrupt              (port_interrupt),
    .irq                         (irq),
    .copy_req                    (copy_req),
    .link_detect_state           (link_detect_state),
    .self_test_running_state     (self_test_running_state),
    .switching_idle_state        (switching_idle_state),
    .port_idle_state             (port_idle_state),
    .aggressive_pm_check_state   (aggressive_pm_check_state)
  );
  frc_mem_model mem (.sys_clk(sys_clk), .reset(reset), .copy_req(copy_req), .lat(lat),
                     .copy_done(copy_done));
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // exit flags are one-cycle pulses: {switching, idle, pm}
  task automatic wait_exit(output logic [2:0] ex);
    ex = 3'h0;
    for (int i = 0; i < 40 && ex == 3'h0; i++) begin
      tick(1);
      ex = {switching_idle_state, port_idle_state, aggressive_pm_check_state};
    end
    tick(2);
  endtask : wait_exit
  task automatic clear_all;
    @(posedge sys_clk);
    {clr_set_bits_fis_status, clr_unknown_fis_status, clr_unknown_fis_diag_flag,
     clr_pending} <= 4'hf;
    @(posedge sys_clk);
    {clr_set_bits_fis_status, clr_unknown_fis_status, clr_unknown_fis_diag_flag,
     clr_pending} <= 4'h0;
    tick(2);
    check("cleared", {set_bits_fis_status, unknown_fis_status, port_interrupt}, 4'h0);
  endtask : clear_all
  task automatic sdb_case(input logic sa0, input logic fbs, input logic gie, input logic sdbe);
    logic [2:0] ex;
    @(posedge sys_clk);
    {sdb_active_zero, fis_switching_enable, global_interrupt_enable} <= {sa0, fbs, gie};
    set_bits_fis_int_enable <= sdbe;
    sdb_fis_int <= 1'b1;
    @(posedge sys_clk);
    sdb_fis_int <= 1'b0;
    wait_exit(ex);
    check("sdb status", set_bits_fis_status, 4'h1);
    check("sdb pending", port_interrupt_pending_bits, sdbe);
    check("sdb intr", port_interrupt, sdbe & gie);
    check("irq", irq, sdbe & gie);
    check("sdb exit", ex, sa0 ? (fbs ? 3'h4 : 3'h2) : 3'h1);
    clear_all;
  endtask : sdb_case
  task automatic uf_case(input logic crc, input logic ufe, input logic gie, input logic fbs,
                         input logic [3:0] l);
    logic [2:0] ex;
    @(posedge sys_clk);
    {unknown_fis_crc_ok, unknown_fis_int_enable, global_interrupt_enable} <= {crc, ufe, gie};
    {fis_switching_enable, lat} <= {fbs, l};
    unknown_fis_rx <= 1'b1;
    @(posedge sys_clk);
    unknown_fis_rx <= 1'b0;
    tick(1);
    check("diag", unknown_fis_diag_flag, 4'h1);
    check("copy req", copy_req, crc);
    check("early ufs", unknown_fis_status, 4'h0);
    wait_exit(ex);
    check("ufs", unknown_fis_status, crc);
    check("uf pending", port_interrupt_pending_bits, crc & ufe);
    check("uf intr", port_interrupt, crc & ufe & gie);
    check("uf exit", ex, crc ? (fbs ? 3'h4 : 3'h2) : 3'h0);
    clear_all;
    check("diag clr", unknown_fis_diag_flag, 4'h0);
  endtask : uf_case
  task automatic bist_case;
    @(posedge sys_clk);
    bist_far_end_rx <= 1'b1;
    @(posedge sys_clk);
    bist_far_end_rx <= 1'b0;
    tick(30);
    check("det", link_detect_state, 4'h4);
    check("test run", self_test_running_state, 4'h1);
    @(posedge sys_clk);
    port_run_control <= 1'b0;
    tick(2);
    check("test end", self_test_running_state, 4'h0);
  endtask : bist_case
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {sdb_fis_int, sdb_active_zero, unknown_fis_rx, unknown_fis_crc_ok, bist_far_end_rx} = '0;
    {set_bits_fis_int_enable, unknown_fis_int_enable, global_interrupt_enable} = '0;
    {fis_switching_enable, clr_set_bits_fis_status, clr_unknown_fis_status} = '0;
    {clr_unknown_fis_diag_flag, clr_pending, lat} = '0;
    {reset, port_run_control} = 2'h3;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    sdb_case(1, 1, 1, 1);
    sdb_case(1, 0, 1, 1);
    sdb_case(0, 0, 1, 1);
    sdb_case(1, 0, 0, 1);
    sdb_case(0, 1, 1, 0);
    uf_case(1, 1, 1, 1, 4'h0);
    uf_case(1, 1, 0, 0, 4'h9);
    uf_case(1, 0, 1, 1, 4'h3);
    uf_case(0, 1, 1, 1, 4'h0);
    bist_case;
    report_and_stop;
  end
  initial begin
    #20000;
    miscompares++;
    report_and_stop;
  end
endmodule : tb_frc_fsm
bind frc_fsm frc_props #(.PORTS(PORTS)) chk (
  .sys_clk                     (sys_clk),
  .reset                       (reset),
  .sdb_fis_int                 (sdb_fis_int),
  .unknown_fis_rx              (unknown_fis_rx),
  .unknown_fis_crc_ok          (unknown_fis_crc_ok),
  .copy_done                   (copy_done),
  .global_interrupt_enable     (global_interrupt_enable),
  .port_run_control            (port_run_control),
  .clr_pending                 (clr_pending),
  .set_bits_fis_status         (set_bits_fis_status),
  .unknown_fis_status          (unknown_fis_status),
  .unknown_fis_diag_flag       (unknown_fis_diag_flag),
  .port_interrupt_pending_bits (port_interrupt_pending_bits),
  .port_interrupt              (port_interrupt),
  .irq                         (irq),
  .copy_req                    (copy_req),
  .link_detect_state           (link_detect_state),
  .self_test_running_state     (self_test_running_state)
);
